// File: hw/jcp_map.vh
// jcp_map.vh: constants of the configuration test port
// assumes: included by the port module and the test bench
`ifndef JCP_MAP_VH
`define JCP_MAP_VH

// -----------------------------------------------------------------
// instruction register
// -----------------------------------------------------------------
`define JCP_IR_W          4
`define JCP_IR_RESET      4'h1
`define JCP_IR_CAPTURE    4'h1
`define JCP_OP_EXTEST     4'h0
`define JCP_OP_IDCODE     4'h1
`define JCP_OP_SAMPLE     4'h2
`define JCP_OP_CFG_IO     4'h3
`define JCP_OP_PROGRAM    4'h4
`define JCP_OP_CHK_DONE   4'h5
`define JCP_OP_STARTUP    4'h6
`define JCP_OP_BYPASS     4'hF

// -----------------------------------------------------------------
// identity code (value arbitrary)
// -----------------------------------------------------------------
`define JCP_IDCODE        32'h0A5C_3001

// -----------------------------------------------------------------
// initialization clocks after last bit
// -----------------------------------------------------------------
`define JCP_INIT_CYCLES   1094
`define JCP_INIT_W        11

// -----------------------------------------------------------------
// controller states
// -----------------------------------------------------------------
`define JCP_TLR   4'h0
`define JCP_RTI   4'h1
`define JCP_SDR   4'h2
`define JCP_CDR   4'h3
`define JCP_SHDR  4'h4
`define JCP_E1DR  4'h5
`define JCP_PDR   4'h6
`define JCP_E2DR  4'h7
`define JCP_UDR   4'h8
`define JCP_SIR   4'h9
`define JCP_CIR   4'hA
`define JCP_SHIR  4'hB
`define JCP_E1IR  4'hC
`define JCP_PIR   4'hD
`define JCP_E2IR  4'hE
`define JCP_UIR   4'hF

`endif

// File: hw/jcp_port.v
// jcp_port.v: test access port that also loads configuration data
// assumes: test pins come from outside, sampled here on clock_i;
// configuration bits are taken by logic on clock_i downstream
//
// What this block does
// - test port configuration pre-empts any running passive serial load
// - data loaded here skips decompression and decryption
// - port has data in, data out, mode select, clock, optional reset
// - user pins held tri-stated throughout test port configuration
// - data in sampled on each rising test clock edge
// - data out changes on falling test clock edge
// - data out released when nothing is being shifted
// - mode select sampled on rising edge to pick next state
// - state change applied at the following falling edge
// - low test reset clears scan logic without waiting for clock
// - port stays inert with inputs idle high or clock low
// - bypass passes each bit through one register stage
// - 1094 extra test clocks after last bit run initialization
// - done flag rises after successful load, readable via port
// - only bypass, id, sample, program and config io ops run during configuration
`timescale 1ns/1ps
`include "jcp_map.vh"

module jcp_port #(
  parameter BS_W      = 8,
  parameter INIT_CYC  = `JCP_INIT_CYCLES
) (
  // system
  input  wire            clock_i,
  input  wire            reset_n_i,
  // test pins
  input  wire            tck_i,
  input  wire            tms_i,
  input  wire            tdi_i,
  input  wire            trst_n_i,
  output reg             tdo_o,
  output reg             tdo_oe_n_o,
  // device side
  input  wire            passive_serial_mode_i,
  input  wire [BS_W-1:0] pin_sample_i,
  output reg             passive_serial_abort_o,
  output reg             user_io_tristate_o,
  output reg             cfg_bit_valid_o,
  output reg             cfg_bit_o,
  output reg             config_done_flag_o
);

  // -----------------------------------------------------------------
  // input synchronisers
  // -----------------------------------------------------------------
  reg [3:0] s1_r;
  reg [3:0] s2_r;
  reg       tck_d_r;
  always @(posedge clock_i) begin
    if (!reset_n_i) begin
      // idle pin levels, so no false tck edge follows reset
      s1_r    <= 4'hB;
      s2_r    <= 4'hB;
      tck_d_r <= 1'b0;
    end else begin
      s1_r    <= {trst_n_i, tck_i, tms_i, tdi_i};
      s2_r    <= s1_r;
      tck_d_r <= s2_r[2];
    end
  end
  wire trst_n = s2_r[3];
  wire tck_s  = s2_r[2];
  wire tms_s  = s2_r[1];
  wire tdi_s  = s2_r[0];
  wire rise   = tck_s & ~tck_d_r;
  wire fall   = ~tck_s & tck_d_r;
  // test reset acts on every system clock, not a tck edge
  wire clr    = ~reset_n_i | ~trst_n;

  // -----------------------------------------------------------------
  // controller
  // -----------------------------------------------------------------
  function [3:0] jcp_next;
    input [3:0] st;
    input       m;
    begin
      case (st)
        `JCP_TLR:  jcp_next = m ? `JCP_TLR  : `JCP_RTI;
        `JCP_RTI:  jcp_next = m ? `JCP_SDR  : `JCP_RTI;
        `JCP_SDR:  jcp_next = m ? `JCP_SIR  : `JCP_CDR;
        `JCP_CDR:  jcp_next = m ? `JCP_E1DR : `JCP_SHDR;
        `JCP_SHDR: jcp_next = m ? `JCP_E1DR : `JCP_SHDR;
        `JCP_E1DR: jcp_next = m ? `JCP_UDR  : `JCP_PDR;
        `JCP_PDR:  jcp_next = m ? `JCP_E2DR : `JCP_PDR;
        `JCP_E2DR: jcp_next = m ? `JCP_UDR  : `JCP_SHDR;
        `JCP_UDR:  jcp_next = m ? `JCP_SDR  : `JCP_RTI;
        `JCP_SIR:  jcp_next = m ? `JCP_TLR  : `JCP_CIR;
        `JCP_CIR:  jcp_next = m ? `JCP_E1IR : `JCP_SHIR;
        `JCP_SHIR: jcp_next = m ? `JCP_E1IR : `JCP_SHIR;
        `JCP_E1IR: jcp_next = m ? `JCP_UIR  : `JCP_PIR;
        `JCP_PIR:  jcp_next = m ? `JCP_E2IR : `JCP_PIR;
        `JCP_E2IR: jcp_next = m ? `JCP_UIR  : `JCP_SHIR;
        `JCP_UIR:  jcp_next = m ? `JCP_SDR  : `JCP_RTI;
        default:   jcp_next = `JCP_TLR;
      endcase
    end
  endfunction

  reg [3:0]             state_r;
  reg [3:0]             pend_r;
  reg [`JCP_IR_W-1:0]   ir_sh_r;
  reg [`JCP_IR_W-1:0]   ir_r;
  reg [31:0]            dr_sh_r;
  reg                   byp_r;
  reg                   cfg_act_r;
  reg                   loaded_r;
  reg [`JCP_INIT_W-1:0] init_cnt_r;
  reg                   init_run_r;

  wire in_shdr  = (state_r == `JCP_SHDR);
  wire in_shir  = (state_r == `JCP_SHIR);
  // only bypass, id, sample, program and config io ops survive a running configuration
  wire safe_op  = (ir_sh_r == `JCP_OP_BYPASS) |
                  (ir_sh_r == `JCP_OP_IDCODE) |
                  (ir_sh_r == `JCP_OP_SAMPLE) |
                  (ir_sh_r == `JCP_OP_PROGRAM) |
                  (ir_sh_r == `JCP_OP_CFG_IO);
  wire ir_take  = ~cfg_act_r | safe_op;
  // program opcode being loaded at this update
  wire prog_load = (state_r == `JCP_UIR) & ir_take &
                   (ir_sh_r == `JCP_OP_PROGRAM);

  // -----------------------------------------------------------------
  // rising edge: sample tms/tdi, shift
  // -----------------------------------------------------------------
  always @(posedge clock_i) begin
    if (clr) begin
      pend_r     <= `JCP_TLR;
      ir_sh_r    <= `JCP_IR_RESET;
      dr_sh_r    <= 32'h0000_0000;
      byp_r      <= 1'b0;
      cfg_bit_valid_o <= 1'b0;
      cfg_bit_o  <= 1'b0;
      init_cnt_r <= {`JCP_INIT_W{1'b0}};
      init_run_r <= 1'b0;
      config_done_flag_o <= 1'b0;
    end else begin
      cfg_bit_valid_o <= 1'b0;
      if (rise) begin
        pend_r <= jcp_next(state_r, tms_s);
        if (state_r == `JCP_CIR)
          ir_sh_r <= `JCP_IR_CAPTURE;
        // data in taken on rising edge
        else if (in_shir)
          ir_sh_r <= {tdi_s, ir_sh_r[`JCP_IR_W-1:1]};
        if (state_r == `JCP_CDR) begin
          byp_r <= 1'b0;
          case (ir_r)
            `JCP_OP_IDCODE:   dr_sh_r <= `JCP_IDCODE;
            `JCP_OP_SAMPLE,
            `JCP_OP_EXTEST:   dr_sh_r <= {{(32-BS_W){1'b0}}, pin_sample_i};
            `JCP_OP_CHK_DONE: dr_sh_r <= {31'h0, config_done_flag_o};
            default:          dr_sh_r <= 32'h0000_0000;
          endcase
        end else if (in_shdr) begin
          byp_r   <= tdi_s;
          dr_sh_r <= {tdi_s, dr_sh_r[31:1]};
          // raw bits forwarded, no decompress or decrypt
          if (ir_r == `JCP_OP_PROGRAM && cfg_act_r) begin
            cfg_bit_valid_o <= 1'b1;
            cfg_bit_o       <= tdi_s;
          end
        end
        // count initialization clocks after the load
        if (ir_r == `JCP_OP_STARTUP && loaded_r && !config_done_flag_o
            && state_r == `JCP_RTI) begin
          init_run_r <= 1'b1;
          if (init_cnt_r == INIT_CYC[`JCP_INIT_W-1:0] - 1'b1)
            config_done_flag_o <= 1'b1;
          else
            init_cnt_r <= init_cnt_r + 1'b1;
        end
        if (ir_r == `JCP_OP_PROGRAM && state_r == `JCP_UDR) begin
          init_cnt_r <= {`JCP_INIT_W{1'b0}};
          config_done_flag_o <= 1'b0;
        end
      end
    end
  end

  // -----------------------------------------------------------------
  // falling edge: apply state, update, drive tdo
  // -----------------------------------------------------------------
  always @(posedge clock_i) begin
    if (clr) begin
      state_r    <= `JCP_TLR;
      ir_r       <= `JCP_IR_RESET;
      cfg_act_r  <= 1'b0;
      loaded_r   <= 1'b0;
      tdo_o      <= 1'b1;
      tdo_oe_n_o <= 1'b1;
      user_io_tristate_o     <= 1'b0;
      passive_serial_abort_o <= 1'b0;
    end else if (fall) begin
      // transition lands on the falling edge
      state_r <= pend_r;
      if (pend_r == `JCP_TLR)
        ir_r <= `JCP_IR_RESET;
      else if (state_r == `JCP_UIR && ir_take) begin
        ir_r <= ir_sh_r;
        if (ir_sh_r == `JCP_OP_PROGRAM) begin
          cfg_act_r  <= 1'b1;
          loaded_r   <= 1'b0;
        end else if (ir_sh_r == `JCP_OP_CFG_IO && cfg_act_r) begin
          cfg_act_r  <= 1'b0;
        end
      end
      if (state_r == `JCP_UDR && ir_r == `JCP_OP_PROGRAM) begin
        loaded_r  <= 1'b1;
        cfg_act_r <= 1'b0;
      end
      passive_serial_abort_o <= (cfg_act_r | (state_r == `JCP_UIR &&
        ir_sh_r == `JCP_OP_PROGRAM)) & passive_serial_mode_i;
      user_io_tristate_o <= cfg_act_r | prog_load |
                            (loaded_r & ~config_done_flag_o);
      if (pend_r == `JCP_SHIR) begin
        tdo_oe_n_o <= 1'b0;
        // capture value already sits in ir_sh_r on entry
        tdo_o      <= ir_sh_r[0];
      end else if (pend_r == `JCP_SHDR) begin
        tdo_oe_n_o <= 1'b0;
        if (ir_r == `JCP_OP_BYPASS || ir_r == `JCP_OP_PROGRAM ||
            ir_r == `JCP_OP_STARTUP || ir_r == `JCP_OP_CFG_IO)
          tdo_o <= (state_r == `JCP_SHDR) ? byp_r : 1'b0;
        else
          tdo_o <= dr_sh_r[0];
      end else begin
        tdo_oe_n_o <= 1'b1;
        tdo_o      <= 1'b1;
      end
    end
  end
  // idle-high tms parks controller in reset; low tck has no edges

endmodule // jcp_port

// File: testbench/jcp_master.sv
// jcp_master.sv: behavioural test-port master, tck 8 clocks a period
// assumes: tasks start at a rising clock_i edge
`timescale 1ns/1ps
module jcp_master (
  input  wire clock_i,
  input  wire tdo_i,
  output reg  tck_o = 1'b0,
  output reg  tms_o = 1'b1,
  output reg  tdi_o = 1'b1,
  output reg  trst_n_o = 1'b1
);
  // mode and bit set ahead of rise
  task step(input mv, input dv, output qv);
    begin
      tms_o <= mv;
      tdi_o <= dv;
      repeat (4) @(posedge clock_i);
      tck_o <= 1'b1;
      qv = tdo_i;
      repeat (4) @(posedge clock_i);
      tck_o <= 1'b0;
    end
  endtask
  // idle data line toggles outside shifts
  task moves(input [3:0] pat, input integer n);
    integer i;
    reg     b;
    for (i = 0; i < n; i = i + 1)
      step(pat[i], ~tdi_o, b);
  endtask
  // one bit per tck period, lsb first
  task sh(input integer n, input [31:0] din, output [31:0] dout);
    integer i;
    reg     b;
    begin
      dout = 32'h0000_0000;
      for (i = 0; i < n; i = i + 1) begin
        step(i == n - 1, din[i], b);
        dout[i] = b;
      end
    end
  endtask
  task ir(input [3:0] op);
    reg [31:0] x;
    begin
      moves(4'h3, 4);
      sh(4, {28'h0, op}, x);
      moves(4'h1, 2);
      repeat (4) @(posedge clock_i);
    end
  endtask
  task dr(input integer n, input [31:0] din, output [31:0] dout);
    begin
      moves(4'h1, 3);
      sh(n, din, dout);
      moves(4'h1, 2);
      repeat (4) @(posedge clock_i);
    end
  endtask
  task treset;
    begin
      trst_n_o <= 1'b0;
      repeat (8) @(posedge clock_i);
      trst_n_o <= 1'b1;
      repeat (4) @(posedge clock_i);
    end
  endtask
endmodule // jcp_master

// File: testbench/jcp_port_asserts.sv
// jcp_port_asserts.sv: port checks of the configuration test port
// assumes: bound to jcp_port, test pins idle with tck low
`timescale 1ns/1ps
module jcp_port_asserts (
  input wire clock_i,
  input wire reset_n_i,
  input wire tck_i,
  input wire passive_serial_mode_i,
  input wire tdo_o,
  input wire tdo_oe_n_o,
  input wire passive_serial_abort_o,
  input wire user_io_tristate_o,
  input wire cfg_bit_valid_o,
  input wire config_done_flag_o
);
  default clocking cb @(posedge clock_i); endclocking
  // ------------------------------------------------------------
  // sequences and properties
  // ------------------------------------------------------------
  sequence s_rel;
    tdo_oe_n_o && tdo_o;
  endsequence
  sequence s_tck_lo;
    !tck_i && !$past(tck_i);
  endsequence
  property p_rst;
    !reset_n_i |=> s_rel ##0 (!cfg_bit_valid_o && !config_done_flag_o);
  endproperty
  property p_oe;
    disable iff (!reset_n_i) tdo_oe_n_o |-> tdo_o;
  endproperty
  property p_fall;
    disable iff (!reset_n_i)
      ($changed(tdo_o) || $changed(tdo_oe_n_o)) |-> s_tck_lo;
  endproperty
  property p_take;
    disable iff (!reset_n_i) cfg_bit_valid_o |-> tck_i && $past(tck_i);
  endproperty
  property p_pulse;
    disable iff (!reset_n_i) cfg_bit_valid_o |=> !cfg_bit_valid_o;
  endproperty
  property p_tri;
    disable iff (!reset_n_i) cfg_bit_valid_o |-> user_io_tristate_o;
  endproperty
  property p_abort;
    disable iff (!reset_n_i)
      cfg_bit_valid_o && passive_serial_mode_i |-> passive_serial_abort_o;
  endproperty
  property p_done;
    disable iff (!reset_n_i)
      $rose(config_done_flag_o) |-> ##[0:4] !user_io_tristate_o;
  endproperty
  a_rst:   assert property (p_rst)   else $error("reset state wrong");
  a_oe:    assert property (p_oe)    else $error("tdo not 1 when off");
  a_fall:  assert property (p_fall)  else $error("tdo moved off fall");
  a_take:  assert property (p_take)  else $error("bit not on rise");
  a_pulse: assert property (p_pulse) else $error("bit pulse too long");
  a_tri:   assert property (p_tri)   else $error("pins not high-Z");
  a_abort: assert property (p_abort) else $error("serial not aborted");
  a_done:  assert property (p_done)  else $error("pins kept high-Z");
endmodule // jcp_port_asserts

bind jcp_port jcp_port_asserts u_chk (
  .clock_i(clock_i), .reset_n_i(reset_n_i), .tck_i(tck_i),
  .passive_serial_mode_i(passive_serial_mode_i), .tdo_o(tdo_o),
  .tdo_oe_n_o(tdo_oe_n_o), .passive_serial_abort_o(passive_serial_abort_o),
  .user_io_tristate_o(user_io_tristate_o),
  .cfg_bit_valid_o(cfg_bit_valid_o),
  .config_done_flag_o(config_done_flag_o));

// File: testbench/jcp_port_test.sv
// jcp_port_test.sv: self-checking bench of the configuration test port
// assumes: jcp_master drives the pins, checker bound to uut
`timescale 1ns/1ps
`include "jcp_map.vh"
module jcp_port_test;
  localparam INIT = 8;
  reg         clock_i   = 1'b0;
  reg         reset_n_i = 1'b0;
  reg         ps_mode   = 1'b0;
  wire        tck, tms, tdi, trst_n, tdo, oe_n, abort, tri_o, cv, cb, done;
  reg  [7:0]  cfg_q     = 8'h00;
  integer     cfg_n     = 0;
  integer     bad_count = 0;
  integer     compares  = 0;
  reg  [31:0] q;
  reg         d;
  always #50 clock_i = ~clock_i;
  jcp_port #(.BS_W(8), .INIT_CYC(INIT)) uut (
    .clock_i(clock_i), .reset_n_i(reset_n_i), .tck_i(tck), .tms_i(tms),
    .tdi_i(tdi), .trst_n_i(trst_n), .tdo_o(tdo), .tdo_oe_n_o(oe_n),
    .passive_serial_mode_i(ps_mode), .pin_sample_i(8'hA5),
    .passive_serial_abort_o(abort), .user_io_tristate_o(tri_o),
    .cfg_bit_valid_o(cv), .cfg_bit_o(cb), .config_done_flag_o(done));
  jcp_master m (.clock_i(clock_i), .tdo_i(tdo), .tck_o(tck), .tms_o(tms),
    .tdi_o(tdi), .trst_n_o(trst_n));
  always @(posedge clock_i) begin
    if (cv === 1'b1) begin
      cfg_q <= {cb, cfg_q[7:1]};
      cfg_n <= cfg_n + 1;
    end
  end
  task chk(input [8*8:1] nm, input [31:0] e, input [31:0] g);
    begin
      compares = compares + 1;
      if (g !== e) begin
        bad_count = bad_count + 1;
        $display("Error %0s expected %h seen %h", nm, e, g);
      end
    end
  endtask
  task end_of_test;
    begin
      $display("compares %0d mismatches %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0)
        $display("DONE - PASS");
      else
        $display("DONE - FAIL");
      $finish;
    end
  endtask
  task t_idle_id;
    begin
      repeat (20) @(posedge clock_i);
      chk("oe_idle", 1, oe_n);
      chk("tri_idl", 0, tri_o);
      m.step(1'b0, 1'b1, d);
      m.dr(32, 32'h0, q);
      chk("idcode", `JCP_IDCODE, q);
      m.ir(`JCP_OP_BYPASS);
      m.dr(8, 32'hD3, q);
      chk("bypass", 32'hA6, q);
      $display("test idle, idcode and bypass finished");
    end
  endtask
  task t_trst;
    begin
      m.treset;
      chk("oe_trst", 1, oe_n);
      m.step(1'b0, 1'b1, d);
      m.dr(32, 32'h0, q);
      chk("id_trst", `JCP_IDCODE, q);
      $display("test test-reset finished");
    end
  endtask
  task t_program;
    begin
      ps_mode <= 1'b1;
      m.ir(`JCP_OP_PROGRAM);
      chk("abort", 1, abort);
      chk("tri_on", 1, tri_o);
      m.ir(`JCP_OP_IDCODE);
      m.dr(32, 32'h0, q);
      chk("id_cfg", `JCP_IDCODE, q);
      m.ir(`JCP_OP_EXTEST);
      m.dr(32, 32'h0, q);
      chk("refused", `JCP_IDCODE, q);
      m.ir(`JCP_OP_SAMPLE);
      m.dr(8, 32'h0, q);
      chk("sample", 32'hA5, q);
      chk("tri_on", 1, tri_o);
      m.ir(`JCP_OP_PROGRAM);
      chk("abort", 1, abort);
      m.dr(8, 32'h9C, q);
      chk("cfg_n", 8, cfg_n);
      chk("cfg_q", 32'h9C, cfg_q);
      chk("tri_ld", 1, tri_o);
      $display("test program finished");
    end
  endtask
  task t_startup;
    begin
      m.ir(`JCP_OP_STARTUP);
      repeat (INIT - 1) m.step(1'b0, 1'b0, d);
      chk("early", 0, done);
      chk("tri_ini", 1, tri_o);
      m.step(1'b0, 1'b0, d);
      repeat (4) @(posedge clock_i);
      chk("done", 1, done);
      chk("tri_off", 0, tri_o);
      m.ir(`JCP_OP_CHK_DONE);
      m.dr(1, 32'h0, q);
      chk("rd_done", 1, q[0]);
      $display("test startup finished");
    end
  endtask
  initial begin
    repeat (2) @(posedge clock_i);
    reset_n_i <= 1'b1;
    repeat (3) @(posedge clock_i);
    t_idle_id;
    t_trst;
    t_program;
    t_startup;
    end_of_test;
  end
  initial begin
    repeat (20000) @(posedge clock_i);
    bad_count = bad_count + 1;
    end_of_test;
  end
endmodule // jcp_port_test
